// [rtl/ian_arbiter.sv]
`timescale 1ns/1ps
// combinational arbiter: winning vector and its level
module ian_arbiter
  import ian_pkg::*;
(
  input wire logic [ian_pkg::NUM_VEC-1:0] srcEnable,
  input wire logic [ian_pkg::NUM_VEC-1:0] srcRequest,
  input wire logic [2*ian_pkg::NUM_VEC-1:0] srcLevel,
  input wire logic nmiReq,
  output logic winValid,
  output logic [4:0] winVector,
  output logic [1:0] winLevel,
  output logic winNmi
);
  always_comb begin
    winValid = 1'b0;
    winVector = 5'h00;
    winLevel = 2'h3;
    winNmi = 1'b0;
    // lowest level wins, ties to the lower vector
    for (int i = NUM_VEC - 1; i >= FIRST_MASKABLE; i--) begin
      if (srcEnable[i] && srcRequest[i] && srcLevel[2*i +: 2] != 2'h3 &&
          (!winValid || srcLevel[2*i +: 2] <= winLevel)) begin
        winValid = 1'b1;
        winVector = 5'(i);
        winLevel = srcLevel[2*i +: 2];
      end
    end
    if (nmiReq) begin
      winValid = 1'b1;
      winNmi = 1'b1;
      winVector = VEC_NMI;
      winLevel = 2'h0;
    end
  end
endmodule

// [rtl/ian_pkg.sv]
// package of constants and types for the interrupt acceptance and nesting block
package ian_pkg;
  localparam int NUM_VEC = 32;
  localparam int FIRST_MASKABLE = 2;
  localparam logic [4:0] VEC_NMI = 5'h01;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // status word field positions
  localparam int MIE_BIT = 6;
  localparam int IM_LO = 4;
  // stack frame
  localparam logic [15:0] FRAME_BYTES = 16'h0006;
  localparam logic [2:0] OFS_STATUS = 3'h0;
  localparam logic [2:0] OFS_PC_LO = 3'h1;
  localparam logic [2:0] OFS_PC_MID = 3'h2;
  localparam logic [2:0] OFS_PC_HI = 3'h3;
  localparam logic [2:0] OFS_AUX_LO = 3'h4;
  localparam logic [2:0] OFS_AUX_HI = 3'h5;
  // vector table
  localparam logic [18:0] VEC_BASE = 19'h04000;
  localparam logic [18:0] VEC_STRIDE_SHIFT = 19'h00002;
  // wishbone register offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_SP = 4'h4;
  localparam logic [3:0] REG_PC = 4'h8;
  localparam logic [3:0] REG_AUX = 4'hc;
  typedef enum {
    IAN_IDLE, IAN_SPDEC, IAN_AUXH, IAN_AUXL, IAN_PCH, IAN_PCM, IAN_PCL, IAN_PSW,
    IAN_MASK, IAN_VEC, IAN_RST, IAN_RPCL, IAN_RPCM, IAN_RPCH, IAN_RAUXL,
    IAN_RAUXH, IAN_RSPI, IAN_RBR
  } ian_state_t;
endpackage

// [rtl/ian_top.sv]
`timescale 1ns/1ps
// interrupt acceptance, stack save/restore and nesting sequencer
// Function
// - equal level: lower vector number wins
// - acceptance never clears global enable
// - global enable changed only by software, reset, return
// - reset forces mask level to 00
// - mask changes: write, reset, accept, return
// - non-maskable beats maskable in same cycle
// - nest only if level below mask
// - held request taken after return raises mask
// - first step: stack pointer minus six
// - aux high at +5, low at +4
// - status word stored at new stack pointer
// - mask loaded with accepted maskable source level
// - last step: branch to vector table entry
// - return restores status, pc, aux, sp+6, branches
// - accept: enable, source enable, level below mask
// - mask 0 nmi only, 3 admits 0..2
// - acceptance clears request flag, keeps enable
// - non-maskable always accepted
module ian_top
  import ian_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // core side
  input wire logic instrBoundary,
  input wire logic rtiReq,
  input wire logic [ian_pkg::NUM_VEC-1:0] srcEnable,
  input wire logic [ian_pkg::NUM_VEC-1:0] srcRequest,
  input wire logic [2*ian_pkg::NUM_VEC-1:0] srcLevel,
  input wire logic nmiReq,
  input wire logic [15:0] auxPointerIn,
  input wire logic auxPointerLoad,
  output logic [ian_pkg::NUM_VEC-1:0] reqClear,
  output logic memReq,
  output logic memWe,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  input wire logic memAck,
  output logic busy,
  output logic branch,
  output logic [18:0] branchAddr,
  output logic [4:0] acceptedVector
);
  typedef struct packed {
    ian_state_t st;
    logic [7:0] statusWord;
    logic [15:0] sp;
    logic [18:0] pc;
    logic [15:0] auxPointerReg;
    logic [4:0] vec;
    logic [1:0] lvl;
    logic nmi;
    logic [23:0] tmp;
    logic [31:0] wbDat;
    logic wbAck;
    logic [NUM_VEC-1:0] reqClear;
    logic memReq;
    logic memWe;
    logic [15:0] memAddr;
    logic [7:0] memWdata;
    logic branch;
    logic busy;
  } ian_state_s_t;

  ian_state_s_t s_q, s_d;
  logic winValid;
  logic [4:0] winVector;
  logic [1:0] winLevel;
  logic winNmi;
  logic admit;
  logic wbHit;

  ian_arbiter uArb (
    .srcEnable(srcEnable),
    .srcRequest(srcRequest),
    .srcLevel(srcLevel),
    .nmiReq(nmiReq),
    .winValid(winValid),
    .winVector(winVector),
    .winLevel(winLevel),
    .winNmi(winNmi)
  );

  // mask decode: level must be numerically below mask
  function automatic logic levelAdmitted(input logic [1:0] lvl, input logic [1:0] mask);
    levelAdmitted = lvl < mask;
  endfunction

  always_comb begin
    admit = winValid && (winNmi ||
      (s_q.statusWord[MIE_BIT] && levelAdmitted(winLevel, s_q.statusWord[IM_LO +: 2])));
  end

  assign wbHit = wbCyc && wbStb && !s_q.wbAck;

  // one memory byte step: issue, wait ack, advance
  function automatic logic stepDone(input logic rq, input logic ack);
    stepDone = rq && ack;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.wbAck = 1'b0;
    s_d.reqClear = '0;
    s_d.branch = 1'b0;
    if (auxPointerLoad && s_q.st == IAN_IDLE) begin
      s_d.auxPointerReg = auxPointerIn;
    end
    // register access, one wait state; software writes only while idle
    if (wbHit) begin
      s_d.wbAck = 1'b1;
      s_d.wbDat = 32'h00000000;
      case (wbAdr)
        REG_STATUS: s_d.wbDat = {24'h000000, s_q.statusWord};
        REG_SP: s_d.wbDat = {16'h0000, s_q.sp};
        REG_PC: s_d.wbDat = {13'h0000, s_q.pc};
        REG_AUX: s_d.wbDat = {16'h0000, s_q.auxPointerReg};
        default: s_d.wbDat = 32'h00000000;
      endcase
      if (wbWe && s_q.st == IAN_IDLE) begin
        case (wbAdr)
          REG_STATUS: if (wbSel[0]) s_d.statusWord = wbDatI[7:0];
          REG_SP: begin
            if (wbSel[0]) s_d.sp[7:0] = wbDatI[7:0];
            if (wbSel[1]) s_d.sp[15:8] = wbDatI[15:8];
          end
          REG_PC: begin
            if (wbSel[0]) s_d.pc[7:0] = wbDatI[7:0];
            if (wbSel[1]) s_d.pc[15:8] = wbDatI[15:8];
            if (wbSel[2]) s_d.pc[18:16] = wbDatI[18:16];
          end
          REG_AUX: begin
            if (wbSel[0]) s_d.auxPointerReg[7:0] = wbDatI[7:0];
            if (wbSel[1]) s_d.auxPointerReg[15:8] = wbDatI[15:8];
          end
          default: ;
        endcase
      end
    end
    if (stepDone(s_q.memReq, memAck)) begin
      s_d.memReq = 1'b0;
      s_d.memWe = 1'b0;
    end
    case (s_q.st)
      IAN_IDLE: begin
        if (instrBoundary && rtiReq) begin
          s_d.st = IAN_RST;
          s_d.memReq = 1'b1;
          s_d.memAddr = s_q.sp + {13'h0000, OFS_STATUS};
        end else if (instrBoundary && admit) begin
          s_d.vec = winVector;
          s_d.lvl = winLevel;
          s_d.nmi = winNmi;
          if (!winNmi) begin
            s_d.reqClear[winVector] = 1'b1;
          end
          s_d.st = IAN_SPDEC;
        end
      end
      IAN_SPDEC: begin
        s_d.sp = s_q.sp - FRAME_BYTES;
        s_d.st = IAN_AUXH;
      end
      IAN_AUXH: begin
        if (!s_q.memReq) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.sp + {13'h0000, OFS_AUX_HI};
          s_d.memWdata = s_q.auxPointerReg[15:8];
          s_d.st = IAN_AUXL;
        end
      end
      IAN_AUXL: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.sp + {13'h0000, OFS_AUX_LO};
          s_d.memWdata = s_q.auxPointerReg[7:0];
          s_d.st = IAN_PCH;
        end
      end
      IAN_PCH: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.sp + {13'h0000, OFS_PC_HI};
          s_d.memWdata = {5'h00, s_q.pc[18:17], s_q.pc[0]};
          s_d.st = IAN_PCM;
        end
      end
      IAN_PCM: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.sp + {13'h0000, OFS_PC_MID};
          s_d.memWdata = s_q.pc[16:9];
          s_d.st = IAN_PCL;
        end
      end
      IAN_PCL: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.sp + {13'h0000, OFS_PC_LO};
          s_d.memWdata = s_q.pc[8:1];
          s_d.st = IAN_PSW;
        end
      end
      IAN_PSW: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.memReq = 1'b1;
          s_d.memWe = 1'b1;
          s_d.memAddr = s_q.sp;
          s_d.memWdata = s_q.statusWord;
          s_d.st = IAN_MASK;
        end
      end
      IAN_MASK: begin
        if (stepDone(s_q.memReq, memAck)) begin
          // global enable untouched by acceptance
          if (!s_q.nmi) begin
            s_d.statusWord[IM_LO +: 2] = s_q.lvl;
          end
          s_d.st = IAN_VEC;
        end
      end
      IAN_VEC: begin
        s_d.pc = VEC_BASE + ({14'h0000, s_q.vec} << VEC_STRIDE_SHIFT);
        s_d.branch = 1'b1;
        s_d.st = IAN_IDLE;
      end
      IAN_RST: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.statusWord = memRdata;
          s_d.memReq = 1'b1;
          s_d.memAddr = s_q.sp + {13'h0000, OFS_PC_LO};
          s_d.st = IAN_RPCL;
        end
      end
      IAN_RPCL, IAN_RPCM, IAN_RPCH, IAN_RAUXL: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.memReq = 1'b1;
          s_d.memAddr = s_q.memAddr + 16'h0001;
          s_d.tmp = {memRdata, s_q.tmp[23:8]};
          s_d.st = (s_q.st == IAN_RPCL) ? IAN_RPCM :
                   (s_q.st == IAN_RPCM) ? IAN_RPCH :
                   (s_q.st == IAN_RPCH) ? IAN_RAUXL : IAN_RAUXH;
          if (s_q.st == IAN_RPCH) begin
            s_d.pc = {memRdata[2:1], s_q.tmp[23:16], s_q.tmp[15:8], memRdata[0]};
          end
        end
      end
      IAN_RAUXH: begin
        if (stepDone(s_q.memReq, memAck)) begin
          s_d.auxPointerReg = {memRdata, s_q.tmp[23:16]};
          s_d.st = IAN_RSPI;
        end
      end
      IAN_RSPI: begin
        s_d.sp = s_q.sp + FRAME_BYTES;
        s_d.st = IAN_RBR;
      end
      IAN_RBR: begin
        s_d.branch = 1'b1;
        s_d.st = IAN_IDLE;
      end
      default: s_d.st = IAN_IDLE;
    endcase
    if (!rst_n) begin
      s_d = '0;
      s_d.st = IAN_IDLE;
      s_d.statusWord = STATUS_RESET;
      s_d.statusWord[IM_LO +: 2] = MASK_RESET;
    end
    s_d.busy = s_d.st != IAN_IDLE;
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign wbDatO = s_q.wbDat;
  assign wbAck = s_q.wbAck;
  assign reqClear = s_q.reqClear;
  assign memReq = s_q.memReq;
  assign memWe = s_q.memWe;
  assign memAddr = s_q.memAddr;
  assign memWdata = s_q.memWdata;
  assign busy = s_q.busy;
  assign branch = s_q.branch;
  assign branchAddr = s_q.pc;
  assign acceptedVector = s_q.vec;
endmodule

// [testbench/ian_stack_mem.sv]
`timescale 1ns/1ps
// stack memory model on the core-side byte port
module ian_stack_mem (
  input wire logic clk,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata,
  output logic memAck
);
  logic [7:0] mem [256];
  logic [1:0] waitCnt = 2'h0;
  logic slow = 1'b0;
  initial begin
    memAck = 1'b0;
    memRdata = 8'h00;
  end
  // answers alternate prompt and slow; idle data line toggles
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck) begin
      if (waitCnt != 2'h0) begin
        waitCnt <= waitCnt - 2'h1;
      end else begin
        memAck <= 1'b1;
        slow <= !slow;
        waitCnt <= slow ? 2'h0 : 2'h2;
        memRdata <= mem[memAddr[7:0]];
        if (memWe) begin
          mem[memAddr[7:0]] <= memWdata;
        end
      end
    end
  end
endmodule

// [testbench/ian_top_properties.sv]
`timescale 1ns/1ps
// concurrent checks on the acceptance block ports
module ian_top_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic instrBoundary,
  input wire logic rtiReq,
  input wire logic nmiReq,
  input wire logic [31:0] reqClear,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic memAck,
  input wire logic busy,
  input wire logic branch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_follows: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("bus ack late");
  a_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("bus ack too long");
  a_branch_pulse: assert property (branch |=> !branch)
    else $error("branch too long");
  a_clear_single: assert property (reqClear != '0 |-> $onehot(reqClear))
    else $error("several flags cleared");
  a_mem_hold: assert property (memReq && !memAck |=>
    memReq && $stable(memAddr) && $stable(memWdata) && $stable(memWe))
    else $error("stack access not held");
  a_idle_quiet: assert property (!busy |-> !memReq)
    else $error("stack access while idle");
  a_start_boundary: assert property ($rose(busy) |-> $past(instrBoundary))
    else $error("start off boundary");
  a_save_atomic: assert property ($rose(busy) |-> busy [*8])
    else $error("sequence cut short");
  a_nmi_taken: assert property (!busy && instrBoundary && nmiReq && !rtiReq |=> busy)
    else $error("nmi not taken");
  a_seq_bounded: assert property ($rose(busy) |-> ##[7:200] branch)
    else $error("no branch");
  a_save_writes: assert property ($rose(busy) && !$past(rtiReq) |-> ##[1:20] memReq && memWe)
    else $error("no stack write");
endmodule
bind ian_top ian_top_properties props (.*);

// [testbench/interrupt_accept_nesting_bench.sv]
`timescale 1ns/1ps
// self-checking bench for interrupt acceptance and nesting
module interrupt_accept_nesting_bench;
  import ian_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'hf;
  logic [31:0] wbDatI = 32'h0, wbDatO, rd;
  logic instrBoundary = 1'b0, rtiReq = 1'b0, nmiReq = 1'b0, auxPointerLoad = 1'b0;
  logic [NUM_VEC-1:0] srcEnable = '0, srcRequest = '0, srcSet = '0, reqClear, clrSeen = '0;
  logic [2*NUM_VEC-1:0] srcLevel = '0;
  logic [15:0] auxPointerIn = 16'h0, memAddr;
  logic [7:0] memWdata, memRdata;
  logic memReq, memWe, memAck, busy, branch;
  logic [18:0] branchAddr, gotAddr;
  logic [4:0] acceptedVector;
  int n_errors = 0, num_checks = 0;
  always #5 clk = ~clk;
  ian_top dut (.*);
  ian_stack_mem partner (.*);
  // request flags as the sources hold them
  always @(posedge clk) begin
    srcRequest <= (srcRequest | srcSet) & ~reqClear;
    clrSeen <= rst_n ? (clrSeen | reqClear) : '0;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic step(input logic return_from_interrupt_instr);
    @(posedge clk);
    instrBoundary <= 1'b1;
    rtiReq <= return_from_interrupt_instr;
    @(posedge clk);
    instrBoundary <= 1'b0;
    rtiReq <= 1'b0;
  endtask
  task automatic wait_branch(input logic [18:0] e, input string m);
    gotAddr = 19'h7ffff;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      if (branch === 1'b1) begin
        gotAddr = branchAddr;
        break;
      end
    end
    chk(32'(gotAddr), 32'(e), m);
    repeat (2) @(posedge clk);
  endtask
  task automatic idle_chk(input string m);
    step(1'b0);
    repeat (3) @(posedge clk);
    chk(32'(busy), 32'h0, m);
  endtask
  task automatic t_reset();
    rdchk(REG_STATUS, 32'(STATUS_RESET), "status at reset");
    rdchk(REG_SP, 32'h0, "sp at reset");
    rdchk(4'h2, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_accept();
    srcLevel[11:6] <= 6'h16;
    srcEnable <= 32'h38;
    srcSet <= 32'h38;
    auxPointerIn <= 16'hbeef;
    auxPointerLoad <= 1'b1;
    @(posedge clk);
    srcSet <= '0;
    auxPointerLoad <= 1'b0;
    wb(1'b1, REG_SP, 32'h100);
    wb(1'b1, REG_PC, 32'h6a5a5);
    wb(1'b1, REG_STATUS, 32'h30);
    idle_chk("taken while disabled");
    wb(1'b1, REG_STATUS, 32'h70);
    step(1'b0);
    wait_branch(VEC_BASE + 19'h10, "winner vector");
    chk(32'(acceptedVector), 32'h4, "accepted vector");
    chk(clrSeen, 32'h10, "flag clear");
    chk(32'(partner.mem[8'hff]), 32'hbe, "aux high");
    chk(32'(partner.mem[8'hfe]), 32'hef, "aux low");
    chk(32'(partner.mem[8'hfc]), 32'h52, "pc mid");
    chk(32'(partner.mem[8'hfb]), 32'hd2, "pc low");
    chk(32'(partner.mem[8'hfd]), 32'h07, "pc high");
    chk(32'(partner.mem[8'hfa]), 32'h70, "saved status");
    rdchk(REG_SP, 32'hfa, "sp after save");
    rdchk(REG_STATUS, 32'h50, "status after accept");
    $display("test accept done");
  endtask
  task automatic t_nest();
    idle_chk("equal level nested");
    wb(1'b1, REG_STATUS, 32'h60);
    nmiReq <= 1'b1;
    step(1'b0);
    wait_branch(VEC_BASE + 19'h4, "nmi first");
    nmiReq <= 1'b0;
    rdchk(REG_STATUS, 32'h60, "mask after nmi");
    $display("test nest done");
  endtask
  task automatic t_return();
    step(1'b1);
    wait_branch(19'h04010, "return to handler");
    rdchk(REG_SP, 32'hfa, "sp after return");
    step(1'b0);
    wait_branch(VEC_BASE + 19'h14, "held request");
    step(1'b1);
    wait_branch(19'h04010, "second return");
    auxPointerIn <= 16'h1234;
    auxPointerLoad <= 1'b1;
    @(posedge clk);
    auxPointerLoad <= 1'b0;
    rdchk(REG_AUX, 32'h1234, "aux load");
    step(1'b1);
    wait_branch(19'h6a5a5, "return to program");
    rdchk(REG_STATUS, 32'h70, "restored status");
    rdchk(REG_SP, 32'h100, "restored sp");
    rdchk(REG_AUX, 32'hbeef, "restored aux");
    step(1'b0);
    wait_branch(VEC_BASE + 19'h0c, "held low level");
    chk(clrSeen, 32'h38, "all flags cleared");
    $display("test return done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_accept();
    t_nest();
    t_return();
    conclude();
  end
  initial begin
    #50000;
    n_errors++;
    conclude();
  end
endmodule
